//--- logic/updown_wiper_host.sv
`timescale 1ns/1ps
module updown_wiper_host #(
  parameter int T_NVWRITE_NS = 5000000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_up,
  input wire logic [wiper_host_pkg::WIPER_W-1:0] cmd_steps,
  input wire logic cmd_store,
  input wire logic cmd_hv,
  input wire logic cmd_lock,
  output logic cmd_ready,
  output logic cmd_done,
  output logic select_low_level,
  output logic hv_select_level,
  output logic updown,
  output logic [wiper_host_pkg::WIPER_W-1:0] wiper_est,
  output logic locked
);
  import wiper_host_pkg::*;

  localparam int NV_CYCLES_INT = (T_NVWRITE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [19:0] NV_CYCLES = 20'(NV_CYCLES_INT);

  // ----------------------------------------
  // Saturating step
  // ----------------------------------------
  function automatic logic [5:0] sat_step(input logic [5:0] code, input logic up);
    logic [5:0] r;
    r = code;
    if (up && code != WIPER_TOP)
    begin
      r = code + 6'h01;
    end
    else if (!up && code != WIPER_BOTTOM)
    begin
      r = code - 6'h01;
    end
    return r;
  endfunction

  seq_state_t state_reg, state_next;
  logic [19:0] timer_reg, timer_next;
  logic [5:0] steps_reg, steps_next;
  logic up_reg, up_next;
  logic final_reg, final_next;
  logic hv_reg, hv_next;
  logic store_reg, store_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic sel_low_reg, sel_low_next;
  logic sel_hv_reg, sel_hv_next;
  logic ud_reg, ud_next;
  logic [5:0] wiper_reg, wiper_next;
  logic locked_reg, locked_next;
  logic expired;
  logic sel_any;

  assign expired = (timer_reg <= ONE_CYCLE);
  assign sel_any = sel_low_reg | sel_hv_reg;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    timer_next = expired ? timer_reg : timer_reg - ONE_CYCLE;
    steps_next = steps_reg;
    up_next = up_reg;
    final_next = final_reg;
    hv_next = hv_reg;
    store_next = store_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    sel_low_next = sel_low_reg;
    sel_hv_next = sel_hv_reg;
    ud_next = ud_reg;
    wiper_next = wiper_reg;
    locked_next = locked_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          up_next = cmd_up;
          steps_next = cmd_steps;
          hv_next = cmd_hv;
          store_next = cmd_hv | cmd_store;
          final_next = cmd_hv ? cmd_lock : cmd_store; // [R20]
          // With no steps, the line already sits at its end level so no stray edge appears
          ud_next = (cmd_steps == 6'h00) ? (cmd_hv ? cmd_lock : cmd_store) : cmd_up; // [R8] [R20]
          ready_next = 1'b0;
          timer_next = EDGE_CYCLES;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (expired)
        begin
          sel_hv_next = hv_reg; // [R13] [R22]
          sel_low_next = !hv_reg; // [R22]
          timer_next = EDGE_CYCLES;
          state_next = ST_SELECT;
        end
      end
      ST_SELECT, ST_STEP_HIGH:
      begin
        if (expired)
        begin
          timer_next = EDGE_CYCLES;
          if (steps_reg != 6'h00)
          begin
            ud_next = 1'b0;
            state_next = ST_STEP_LOW;
          end
          else
          begin
            ud_next = final_reg; // [R11]
            state_next = ST_END_SET;
          end
        end
      end
      ST_STEP_LOW:
      begin
        if (expired)
        begin
          ud_next = 1'b1; // [R9]
          steps_next = steps_reg - 6'h01;
          if (hv_reg || !locked_reg)
          begin
            wiper_next = sat_step(wiper_reg, up_reg);
          end
          timer_next = EDGE_CYCLES;
          state_next = ST_STEP_HIGH;
        end
      end
      ST_END_SET:
      begin
        if (expired)
        begin
          sel_low_next = 1'b0; // [R11]
          sel_hv_next = 1'b0;
          if (hv_reg)
          begin
            locked_next = final_reg; // [R13]
          end
          timer_next = EDGE_CYCLES;
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        if (expired)
        begin
          timer_next = (store_reg && (hv_reg || !locked_reg)) ? NV_CYCLES : ONE_CYCLE;
          state_next = ST_NV_WAIT;
        end
      end
      ST_NV_WAIT:
      begin
        if (expired)
        begin
          ud_next = 1'b0;
          ready_next = 1'b1;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        sel_low_next = 1'b0;
        sel_hv_next = 1'b0;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= 20'h00000;
      steps_reg <= 6'h00;
      up_reg <= 1'b0;
      final_reg <= 1'b0;
      hv_reg <= 1'b0;
      store_reg <= 1'b0;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      sel_low_reg <= 1'b0;
      sel_hv_reg <= 1'b0;
      ud_reg <= 1'b0;
      wiper_reg <= WIPER_RESET;
      locked_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      steps_reg <= steps_next;
      up_reg <= up_next;
      final_reg <= final_next;
      hv_reg <= hv_next;
      store_reg <= store_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      sel_low_reg <= sel_low_next;
      sel_hv_reg <= sel_hv_next;
      ud_reg <= ud_next;
      wiper_reg <= wiper_next;
      locked_reg <= locked_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign cmd_done = done_reg;
  assign select_low_level = sel_low_reg;
  assign hv_select_level = sel_hv_reg;
  assign updown = ud_reg;
  assign wiper_est = wiper_reg;
  assign locked = locked_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_ONE_LEVEL: assert property (!(sel_low_reg && sel_hv_reg)) // [R22]
    else $error("Both select levels driven");
  AST_DIR_BEFORE_FALL: assert property ($rose(sel_any) |-> $stable(ud_reg) && $past(ud_reg, 2) == ud_reg) // [R8]
    else $error("Up/down moved around select edge");
  AST_STEP_ONLY_EDGE: assert property ($rose(ud_reg) && sel_any && $past(sel_any) |-> $past(state_reg) == ST_STEP_LOW) // [R9]
    else $error("Stray up/down rising edge");
  AST_STEPS_DONE: assert property (state_reg == ST_END_SET |-> steps_reg == 6'h00) // [R9]
    else $error("Steps left at command end");
  AST_STORE_LEVEL: assert property ($fell(sel_any) |-> ud_reg == final_reg && $past(ud_reg) == final_reg) // [R11] [R20]
    else $error("Store level wrong at select rise");
  AST_HOLD_AFTER_RISE: assert property ($fell(sel_any) |-> $stable(ud_reg)[*8]) // [R11]
    else $error("Up/down changed after select rise");
  AST_LOCK_BY_HV: assert property ($changed(locked_reg) |-> $past(hv_reg) && $past(sel_hv_reg)) // [R13]
    else $error("Lock changed without high-voltage command");
  AST_ACCEPT: assert property (cmd_valid && ready_reg |=> !ready_reg ##[1:40] sel_any) // [R8]
    else $error("Accepted command did not select");
  AST_STEP_SPACING: assert property ($rose(ud_reg) |=> ud_reg[*8]) // [R9]
    else $error("Step pulse too short");

  COV_STD_STORE: cover property (sel_low_reg && store_reg ##1 !sel_any);
  COV_HV_LOCK: cover property ($rose(locked_reg));
  COV_STEP: cover property (sel_any && $rose(ud_reg));

endmodule

//--- shared/wiper_host_pkg.sv
// Summary of operation
// R1 - Select driven to low level starts a standard step command, store optional.
// R2 - Extra-high select starts a high-voltage command that always stores the wiper.
// R3 - An undriven select line rests at idle high and starts nothing.
// R4 - With select idle the device ignores the up/down line entirely.
// R5 - Increment moves one position toward terminal A, decrement toward terminal B.
// R6 - Wiper code is six bits: 0x3f is terminal A, 0x00 terminal B.
// R7 - Sixty-four positions exist, every code from zero to 63 valid.
// R8 - Up/down level at select falling edge latches direction; set before edge.
// R9 - Each up/down rising edge steps once; controller makes one edge per step.
// R10 - Wiper saturates at both ends and never wraps.
// R11 - Up/down level at select rising edge decides the nonvolatile store.
// R12 - When locked, standard commands neither step nor store the wiper.
// R13 - Lock changes only through high-voltage commands at the extra-high select level.
// R14 - When locked, high-voltage commands still step the wiper.
// R15 - High-voltage commands use the same edge sequence plus the lock update.
// R16 - At power-up the wiper is recalled from nonvolatile memory.
// R17 - Interface is idle only with select idle and no write pending.
// R18 - High-voltage set has increment, decrement, store-only, each locking or unlocking.
// R19 - The device gives no readback of the wiper code.
// R20 - Up/down high at fall means increment; high at rise requests a store.
// R21 - During a nonvolatile write the device ignores all pin activity.
// R22 - Three-level select is modelled as separate low-level and extra-high digital signals.
package wiper_host_pkg;

  // ----------------------------------------
  // Wiper code
  // ----------------------------------------
  localparam int WIPER_W = 6;
  localparam logic [5:0] WIPER_TOP = 6'h3f;
  localparam logic [5:0] WIPER_BOTTOM = 6'h00;
  localparam logic [5:0] WIPER_RESET = 6'h1f;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int T_EDGE_NS = 1000;
  localparam int TIMER_W = 20;
  localparam logic [19:0] EDGE_CYCLES = 20'((T_EDGE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [19:0] ONE_CYCLE = 20'h00001;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_SELECT = 3'h3,
    ST_STEP_LOW = 3'h2,
    ST_STEP_HIGH = 3'h6,
    ST_END_SET = 3'h7,
    ST_RELEASE = 3'h5,
    ST_NV_WAIT = 3'h4
  } seq_state_t;

endpackage

//--- testbench/pot_device_model.sv
`timescale 1ns/1ps
module pot_device_model #(
  parameter logic [5:0] NV_INIT = 6'h1f,
  parameter int T_WRITE_NS = 3000
) (
  input wire logic select_low_level,
  input wire logic hv_select_level,
  input wire logic updown,
  output logic [5:0] dev_wiper,
  output logic [5:0] dev_nv,
  output logic dev_lock,
  output logic dev_early
);
  time store_end;
  logic selected;
  logic dir_up;
  logic hv_cmd;
  // ----------------------------------------
  // Select level decode
  // ----------------------------------------
  assign selected = select_low_level | hv_select_level;
  initial
  begin
    dev_nv = NV_INIT;
    dev_lock = 1'b0;
    dev_wiper = NV_INIT;
    dir_up = 1'b0;
    hv_cmd = 1'b0;
    dev_early = 1'b0;
    store_end = 0;
  end
  always @(posedge selected)
  begin
    if ($time < store_end)
      dev_early = 1'b1;
    dir_up = updown;
    hv_cmd = hv_select_level;
  end
  // ----------------------------------------
  // Stepping
  // ----------------------------------------
  always @(posedge updown)
  begin
    if (selected && (hv_cmd || !dev_lock))
    begin
      if (dir_up && dev_wiper != 6'h3f)
        dev_wiper = dev_wiper + 6'h01;
      else if (!dir_up && dev_wiper != 6'h00)
        dev_wiper = dev_wiper - 6'h01;
    end
  end
  // Store lasts T_WRITE_NS; a new select inside it is flagged
  always @(negedge selected)
  begin
    if (hv_cmd)
    begin
      dev_nv = dev_wiper;
      dev_lock = updown;
      store_end = $time + T_WRITE_NS;
    end
    else if (updown && !dev_lock)
    begin
      dev_nv = dev_wiper;
      store_end = $time + T_WRITE_NS;
    end
  end
endmodule

//--- testbench/tb_updown_wiper_host.sv
`timescale 1ns/1ps
module tb_updown_wiper_host;
  import wiper_host_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_up = 1'b0;
  logic [WIPER_W-1:0] cmd_steps = 6'h00;
  logic cmd_store = 1'b0;
  logic cmd_hv = 1'b0;
  logic cmd_lock = 1'b0;
  logic cmd_ready, cmd_done, select_low_level, hv_select_level, updown, locked, dev_lock, dev_early;
  logic [WIPER_W-1:0] wiper_est, dev_wiper, dev_nv;
  int n_fail = 0;
  int n_tests = 0;
  int n_cmd = 0;
  logic hung = 1'b0;
  always #50 sys_clk = ~sys_clk;
  updown_wiper_host #(.T_NVWRITE_NS(2000)) u_updown_wiper_host (.sys_clk, .nrst, .cmd_valid, .cmd_up,
    .cmd_steps, .cmd_store, .cmd_hv, .cmd_lock, .cmd_ready, .cmd_done, .select_low_level,
    .hv_select_level, .updown, .wiper_est, .locked);
  pot_device_model u_pot_device_model (.select_low_level, .hv_select_level, .updown, .dev_wiper,
    .dev_nv, .dev_lock, .dev_early);
  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check_code(input logic [5:0] got, input logic [5:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_code({5'h00, got}, {5'h00, exp}, what);
  endtask
  task automatic wrap_up;
    $display("Counts: compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic expect_all(input logic [5:0] w, input logic l, input logic [5:0] nv);
    check_code(wiper_est, w, "host wiper");
    check_code(dev_wiper, w, "device wiper");
    check_code(dev_nv, nv, "stored wiper");
    check_bit(locked, l, "host lock");
    check_bit(dev_lock, l, "device lock");
    check_bit(cmd_ready, 1'b1, "ready");
    check_bit(dev_early, 1'b0, "select during store");
  endtask
  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  task automatic run(input logic up, input logic [5:0] st, input logic sto, input logic hv, input logic lk,
    input logic [5:0] w, input logic l, input logic [5:0] nv);
    int i;
    i = 0;
    if (hung)
      return;
    @(posedge sys_clk);
    #10;
    cmd_valid = 1'b1;
    {cmd_up, cmd_steps, cmd_store, cmd_hv, cmd_lock} = {up, st, sto, hv, lk};
    @(posedge sys_clk);
    #10;
    cmd_valid = 1'b0;
    check_bit(cmd_ready, 1'b0, "busy after accept");
    while (cmd_done !== 1'b1 && i < 3000)
    begin
      @(posedge sys_clk);
      #10;
      i++;
    end
    if (i >= 3000)
    begin
      n_fail++;
      hung = 1'b1;
      $display("CHECK FAILED t=%0t command never finished", $time);
    end
    else
    begin
      expect_all(w, l, nv);
      n_cmd++;
      $display("Test %0d finished", n_cmd);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    #10;
    nrst = 1'b1;
    expect_all(6'h1f, 1'b0, 6'h1f);
    run(1'b1, 6'h03, 1'b1, 1'b0, 1'b0, 6'h22, 1'b0, 6'h22);
    run(1'b0, 6'h02, 1'b0, 1'b0, 1'b0, 6'h20, 1'b0, 6'h22);
    run(1'b1, 6'h3f, 1'b0, 1'b0, 1'b0, 6'h3f, 1'b0, 6'h22);
    run(1'b0, 6'h3f, 1'b1, 1'b0, 1'b0, 6'h00, 1'b0, 6'h00);
    run(1'b1, 6'h01, 1'b0, 1'b1, 1'b1, 6'h01, 1'b1, 6'h01);
    run(1'b1, 6'h05, 1'b1, 1'b0, 1'b0, 6'h01, 1'b1, 6'h01);
    run(1'b1, 6'h02, 1'b0, 1'b1, 1'b1, 6'h03, 1'b1, 6'h03);
    run(1'b0, 6'h01, 1'b0, 1'b1, 1'b0, 6'h02, 1'b0, 6'h02);
    run(1'b0, 6'h00, 1'b0, 1'b1, 1'b1, 6'h02, 1'b1, 6'h02);
    run(1'b0, 6'h00, 1'b0, 1'b1, 1'b0, 6'h02, 1'b0, 6'h02);
    run(1'b1, 6'h01, 1'b0, 1'b0, 1'b0, 6'h03, 1'b0, 6'h02);
    run(1'b1, 6'h00, 1'b1, 1'b0, 1'b0, 6'h03, 1'b0, 6'h03);
    wrap_up();
  end
endmodule
